// >>> bdfm_consts.svh
// Constants for the bidirectional dual-buffer block with mailboxes.
// Included by bare name from the package and the top module.
`ifndef BDFM_CONSTS_SVH
`define BDFM_CONSTS_SVH
`define BDFM_DEPTH 256
`define BDFM_WIDTH 36
`define BDFM_LANE 9
`define BDFM_LANES 4
`define BDFM_OFS_BITS 8
`define BDFM_OFS_RESET 8'h08
`define BDFM_MASK_18 36'h00003FFFF
`define BDFM_MASK_9 36'h0000001FF
`define BDFM_SEL_FIFO 3'h7
`define BDFM_SEL_MAIL 3'h6
`define BDFM_SEL_OFS_ALL 3'h5
`define BDFM_SEL_CTRL 3'h4
`define BDFM_SEL_AE1 3'h3
`define BDFM_SEL_AF1 3'h2
`define BDFM_SEL_AE2 3'h1
`define BDFM_SEL_AF2 3'h0
`define BDFM_SELB_FIFO 1'h1
`define BDFM_WS_36 2'h0
`define BDFM_WS_18 2'h1
`define BDFM_WS_9 2'h2
`define BDFM_ADDR_CTRL 12'h000
`define BDFM_ADDR_OFS 12'h004
`define BDFM_ADDR_STAT 12'h008
`define BDFM_PAR_BIT 0
`endif

// >>> bdfm_pkg.sv
// Types shared by the bidirectional dual-buffer block.
// Assumes bdfm_consts.svh is on the include path.
`include "bdfm_consts.svh"
package bdfm_pkg;
	typedef struct packed {
		logic clk;
		logic en;
		logic req;
		logic rnw;
		logic [2:0] sel;
		logic oe_n;
		logic rt;
		logic [`BDFM_WIDTH-1:0] data;
	} bdfm_porta_in_t;

	typedef struct packed {
		logic clk;
		logic en;
		logic req;
		logic rnw;
		logic sel;
		logic oe_n;
		logic rt;
		logic [1:0] ws;
		logic [`BDFM_WIDTH-1:0] data;
	} bdfm_portb_in_t;

	typedef struct packed {
		logic full_n;
		logic afull_n;
		logic half_n;
		logic aempty_n;
		logic empty_n;
	} bdfm_flags_t;
endpackage

// >>> bdfm_sync.sv
// Three-stage input synchroniser for pins from outside the clk domain.
// Assumes a synchronous active-high reset on clk.
`timescale 1ns/1ps
`default_nettype none
module bdfm_sync #(
	parameter int W = 1, // Bundle width.
	parameter logic [W-1:0] INIT = '0 // Level held in reset, the pin's idle value.
) (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic [W-1:0] d, // Asynchronous input.
	output var logic [W-1:0] q // Settled value.
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// A change only counts once stages two and three agree, so a bit caught
	// mid-transition never reaches the logic.
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q <= INIT;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bdfm_top.sv
// Top of the bidirectional dual-buffer block with mailboxes and bypass.
// Assumes all port pins are asynchronous to clk and far slower than it.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bdfm_consts.svh"
module bdfm_top #(
	parameter int DEPTH = `BDFM_DEPTH, // Entries per buffer.
	parameter logic [1:0] WS_36 = `BDFM_WS_36, // Width code for 36 bits.
	parameter logic [1:0] WS_18 = `BDFM_WS_18, // Width code for 18 bits.
	parameter logic [1:0] WS_9 = `BDFM_WS_9 // Width code for 9 bits.
) (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic hsel, // AHB select.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic hwrite, // AHB write.
	input wire logic [2:0] hsize, // AHB size.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB ready in.
	output var logic hreadyout, // AHB ready out.
	output var logic [31:0] hrdata, // AHB read data.
	output var logic hresp, // AHB response.
	input wire logic reset_n, // Device reset pin.
	input wire logic porta_clock, // Port A clock pin.
	input wire logic porta_enable, // Port A enable.
	input wire logic porta_request, // Port A request.
	input wire logic porta_read_not_write, // Port A direction.
	input wire logic porta_select_0, // Port A select bit 0.
	input wire logic porta_select_1, // Port A select bit 1.
	input wire logic porta_select_2, // Port A select bit 2.
	input wire logic porta_output_enable_n, // Port A output enable.
	input wire logic buf2_retransmit, // Buffer 2 retransmit.
	input wire logic [35:0] porta_data_bus_in, // Port A bus level.
	output var logic [35:0] porta_data_bus_out, // Port A drive data.
	output var logic porta_data_bus_oe, // Port A drive enable.
	output var logic porta_acknowledge, // Port A acknowledge.
	output var logic porta_parity_flag, // Port A parity error.
	output var logic buf1_full_n, // Buffer 1 full.
	output var logic buf1_almost_full_n, // Buffer 1 almost full.
	output var logic buf1_half_full_n, // Buffer 1 half full.
	output var logic buf2_almost_empty_n, // Buffer 2 almost empty.
	output var logic buf2_empty_n, // Buffer 2 empty.
	output var logic mailbox2_new_mail, // Mailbox 2 new mail.
	input wire logic portb_clock, // Port B clock pin.
	input wire logic portb_enable, // Port B enable.
	input wire logic portb_request, // Port B request.
	input wire logic portb_read_not_write, // Port B direction.
	input wire logic portb_select, // Port B select.
	input wire logic portb_output_enable_n, // Port B output enable.
	input wire logic portb_width_select_0, // Port B width bit 0.
	input wire logic portb_width_select_1, // Port B width bit 1.
	input wire logic buf1_retransmit, // Buffer 1 retransmit.
	input wire logic [35:0] portb_data_bus_in, // Port B bus level.
	output var logic [35:0] portb_data_bus_out, // Port B drive data.
	output var logic portb_data_bus_oe, // Port B drive enable.
	output var logic portb_acknowledge, // Port B acknowledge.
	output var logic portb_parity_flag, // Port B parity error.
	output var logic buf2_full_n, // Buffer 2 full.
	output var logic buf2_almost_full_n, // Buffer 2 almost full.
	output var logic buf2_half_full_n, // Buffer 2 half full.
	output var logic buf1_almost_empty_n, // Buffer 1 almost empty.
	output var logic buf1_empty_n, // Buffer 1 empty.
	output var logic mailbox1_new_mail // Mailbox 1 new mail.
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	if (DEPTH < 2 || DEPTH > `BDFM_DEPTH || (1 << AW) != DEPTH || WS_36 == WS_18 || WS_18 == WS_9 ||
			WS_36 == WS_9) begin : g_bad_param
		$error("bdfm_top: unsupported depth or width-select codes");
	end

	// ==========================================================
	// Helpers
	function automatic logic [1:0] last_piece(input logic [1:0] ws);
		if (ws == WS_18) begin
			return 2'h1;
		end
		if (ws == WS_9) begin
			return 2'h3;
		end
		return 2'h0;
	endfunction

	function automatic logic [5:0] piece_shift(input logic [1:0] idx, input logic [1:0] last);
		if (last == 2'h1) begin
			return 6'(idx) * 6'(2 * `BDFM_LANE);
		end
		if (last == 2'h3) begin
			return 6'(idx) * 6'(`BDFM_LANE);
		end
		return 6'h00;
	endfunction

	function automatic logic [35:0] piece_mask(input logic [1:0] last);
		if (last == 2'h1) begin
			return `BDFM_MASK_18;
		end
		if (last == 2'h3) begin
			return `BDFM_MASK_9;
		end
		return '1;
	endfunction

	// Error when a lane's xor equals the even-mode bit; only lanes in use count.
	function automatic logic par_err(input logic [35:0] d, input logic even, input logic [1:0] last);
		logic e;
		int n;
		e = 1'b0;
		n = `BDFM_LANES / (int'(last) + 1);
		for (int k = 0; k < `BDFM_LANES; k++) begin
			if (k < n && (^d[k*`BDFM_LANE +: `BDFM_LANE]) == even) begin
				e = 1'b1;
			end
		end
		return e;
	endfunction

	// ==========================================================
	// Pin synchronisers and port clock edges
	bdfm_pkg::bdfm_porta_in_t a_raw, a_s;
	bdfm_pkg::bdfm_portb_in_t b_raw, b_s;
	// Reset to the idle pin levels, so a released output enable is not driven just after reset.
	localparam bdfm_pkg::bdfm_porta_in_t A_IDLE = '{oe_n: 1'b1, default: '0};
	localparam bdfm_pkg::bdfm_portb_in_t B_IDLE = '{oe_n: 1'b1, default: '0};
	logic rstn_s;
	logic a_clk_q, b_clk_q, a_rt_q, b_rt_q;

	assign a_raw = '{clk: porta_clock, en: porta_enable, req: porta_request, rnw: porta_read_not_write,
		sel: {porta_select_2, porta_select_1, porta_select_0}, oe_n: porta_output_enable_n,
		rt: buf2_retransmit, data: porta_data_bus_in};
	assign b_raw = '{clk: portb_clock, en: portb_enable, req: portb_request, rnw: portb_read_not_write,
		sel: portb_select, oe_n: portb_output_enable_n, rt: buf1_retransmit,
		ws: {portb_width_select_1, portb_width_select_0}, data: portb_data_bus_in};

	bdfm_sync #(.W($bits(a_raw)), .INIT(A_IDLE)) u_sync_a (.clk(clk), .reset(reset), .d(a_raw), .q(a_s));
	bdfm_sync #(.W($bits(b_raw)), .INIT(B_IDLE)) u_sync_b (.clk(clk), .reset(reset), .d(b_raw), .q(b_s));
	bdfm_sync #(.W(1)) u_sync_rst (.clk(clk), .reset(reset), .d(reset_n), .q(rstn_s));

	// Clock and data pass the same stages, so data stays aligned to its edge.
	always_ff @(posedge clk) begin
		if (reset) begin
			a_clk_q <= 1'b0;
			b_clk_q <= 1'b0;
			a_rt_q <= 1'b0;
			b_rt_q <= 1'b0;
		end else begin
			a_clk_q <= a_s.clk;
			b_clk_q <= b_s.clk;
			a_rt_q <= a_s.rt;
			b_rt_q <= b_s.rt;
		end
	end

	logic dev_rst, clr, a_edge, b_edge, a_go, b_go;
	logic [1:0] rt_ev, push, pop, full, empty;
	logic [1:0] b_last;
	assign dev_rst = ~rstn_s;
	assign clr = reset | dev_rst;
	assign a_edge = a_s.clk & ~a_clk_q;
	assign b_edge = b_s.clk & ~b_clk_q;
	assign a_go = a_edge & a_s.en;
	assign b_go = b_edge & b_s.en;
	assign rt_ev = {a_s.rt & ~a_rt_q, b_s.rt & ~b_rt_q};
	assign b_last = last_piece(b_s.ws);

	// ==========================================================
	// Buffer access decode
	logic a_fifo, b_fifo, a_wr_ok, a_rd_ok, b_wr_ok, b_rd_ok, b_wr_end, b_rd_end;
	logic [1:0] b_wpc_q, b_rpc_q;
	logic [35:0] b_asm_q, b_asm_d;
	logic [35:0] din [2];
	logic [35:0] head [2];

	assign a_fifo = a_go & a_s.req & (a_s.sel == `BDFM_SEL_FIFO) & ~dev_rst;
	assign b_fifo = b_go & b_s.req & (b_s.sel == `BDFM_SELB_FIFO) & ~dev_rst;
	assign a_wr_ok = a_fifo & ~a_s.rnw & ~full[0] & ~rt_ev[0];
	assign a_rd_ok = a_fifo & a_s.rnw & ~empty[1] & ~rt_ev[1];
	assign b_wr_ok = b_fifo & ~b_s.rnw & ~full[1] & ~rt_ev[1];
	assign b_rd_ok = b_fifo & b_s.rnw & ~empty[0] & ~rt_ev[0];
	assign b_wr_end = b_wpc_q == b_last;
	assign b_rd_end = b_rpc_q == b_last;
	assign b_asm_d = (b_wpc_q == 2'h0 ? '0 : b_asm_q) |
		((b_s.data & piece_mask(b_last)) << piece_shift(b_wpc_q, b_last));
	assign push = {b_wr_ok & b_wr_end, a_wr_ok};
	assign pop = {a_rd_ok, b_rd_ok & b_rd_end};
	assign din[0] = a_s.data;
	assign din[1] = b_asm_d;

	// Narrow port B pieces go low piece first; a word moves only on its last piece.
	always_ff @(posedge clk) begin
		if (clr) begin
			b_wpc_q <= 2'h0;
			b_rpc_q <= 2'h0;
			b_asm_q <= '0;
		end else begin
			if (b_wr_ok) begin
				b_wpc_q <= b_wr_end ? 2'h0 : b_wpc_q + 2'h1;
				b_asm_q <= b_asm_d;
			end
			if (b_rd_ok) begin
				b_rpc_q <= b_rd_end ? 2'h0 : b_rpc_q + 2'h1;
			end
		end
	end

	// ==========================================================
	// Two buffers, index 0 carries A to B, index 1 carries B to A
	logic [35:0] mem_q [2][DEPTH];
	logic [AW-1:0] wr_q [2];
	logic [CW-1:0] rd_q [2];
	logic [CW-1:0] cnt_q [2];

	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (push[i]) begin
				mem_q[i][wr_q[i]] <= din[i];
			end
		end
	end

	// Retransmit rewinds to the first location since reset; reading is counted
	// with one extra bit so a full 256-word block can still be replayed.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (clr) begin
				wr_q[i] <= '0;
				rd_q[i] <= '0;
				cnt_q[i] <= '0;
			end else if (rt_ev[i]) begin
				rd_q[i] <= '0;
				cnt_q[i] <= (cnt_q[i] + rd_q[i] > CW'(DEPTH)) ? CW'(DEPTH) : cnt_q[i] + rd_q[i];
			end else begin
				if (push[i]) begin
					wr_q[i] <= wr_q[i] + AW'(1);
				end
				if (pop[i]) begin
					rd_q[i] <= rd_q[i] + CW'(1);
				end
				cnt_q[i] <= cnt_q[i] + CW'(push[i]) - CW'(pop[i]);
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			head[i] = mem_q[i][rd_q[i][AW-1:0]];
			full[i] = cnt_q[i] == CW'(DEPTH);
			empty[i] = cnt_q[i] == '0;
		end
	end

	// ==========================================================
	// Control, offsets and mailboxes
	logic par_even_q;
	logic [AW-1:0] af_q [2];
	logic [AW-1:0] ae_q [2];
	logic [35:0] mb_q [2];
	logic [1:0] mail_q;
	logic a_cfg, a_mail_wr, a_mail_rd, b_mail_wr, b_mail_rd, ahb_wr_q, ahb_take;
	logic [11:0] ahb_addr_q;

	assign a_cfg = a_go & ~a_s.rnw & ~dev_rst;
	assign a_mail_wr = a_cfg & (a_s.sel == `BDFM_SEL_MAIL);
	assign a_mail_rd = a_go & a_s.rnw & (a_s.sel == `BDFM_SEL_MAIL) & ~dev_rst;
	assign b_mail_wr = b_go & ~b_s.rnw & (b_s.sel != `BDFM_SELB_FIFO) & ~dev_rst;
	assign b_mail_rd = b_go & b_s.rnw & (b_s.sel != `BDFM_SELB_FIFO) & ~dev_rst;

	// Bus writes take priority over a port A write landing in the same cycle.
	always_ff @(posedge clk) begin
		if (clr) begin
			par_even_q <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				af_q[i] <= AW'(`BDFM_OFS_RESET);
				ae_q[i] <= AW'(`BDFM_OFS_RESET);
			end
		end else if (ahb_wr_q) begin
			if (ahb_addr_q == `BDFM_ADDR_CTRL) begin
				par_even_q <= hwdata[`BDFM_PAR_BIT];
			end else if (ahb_addr_q == `BDFM_ADDR_OFS) begin
				ae_q[0] <= hwdata[0*`BDFM_OFS_BITS +: AW];
				af_q[0] <= hwdata[1*`BDFM_OFS_BITS +: AW];
				ae_q[1] <= hwdata[2*`BDFM_OFS_BITS +: AW];
				af_q[1] <= hwdata[3*`BDFM_OFS_BITS +: AW];
			end
		end else if (a_cfg) begin
			unique case (a_s.sel)
				`BDFM_SEL_CTRL: par_even_q <= a_s.data[`BDFM_PAR_BIT];
				`BDFM_SEL_AE1: ae_q[0] <= a_s.data[AW-1:0];
				`BDFM_SEL_AF1: af_q[0] <= a_s.data[AW-1:0];
				`BDFM_SEL_AE2: ae_q[1] <= a_s.data[AW-1:0];
				`BDFM_SEL_AF2: af_q[1] <= a_s.data[AW-1:0];
				`BDFM_SEL_OFS_ALL: begin
					ae_q[0] <= a_s.data[0*`BDFM_LANE +: AW];
					af_q[0] <= a_s.data[1*`BDFM_LANE +: AW];
					ae_q[1] <= a_s.data[2*`BDFM_LANE +: AW];
					af_q[1] <= a_s.data[3*`BDFM_LANE +: AW];
				end
				default: begin
				end
			endcase
		end
	end

	// A new-mail set beats a read-clear in the same cycle.
	always_ff @(posedge clk) begin
		if (clr) begin
			mail_q <= 2'h0;
			mb_q[0] <= '0;
			mb_q[1] <= '0;
		end else begin
			if (a_mail_wr) begin
				mb_q[0] <= a_s.data;
			end
			if (b_mail_wr) begin
				mb_q[1] <= b_s.data;
			end
			mail_q[0] <= a_mail_wr | (mail_q[0] & ~b_mail_rd);
			mail_q[1] <= b_mail_wr | (mail_q[1] & ~a_mail_rd);
		end
	end

	// ==========================================================
	// Port outputs: data, acknowledge, parity, new-mail
	always_ff @(posedge clk) begin
		if (reset) begin
			porta_data_bus_out <= '0;
			portb_data_bus_out <= '0;
			porta_data_bus_oe <= 1'b0;
			portb_data_bus_oe <= 1'b0;
			porta_acknowledge <= 1'b0;
			portb_acknowledge <= 1'b0;
			porta_parity_flag <= 1'b0;
			portb_parity_flag <= 1'b0;
			mailbox1_new_mail <= 1'b0;
			mailbox2_new_mail <= 1'b0;
		end else begin
			porta_data_bus_oe <= ~a_s.oe_n;
			portb_data_bus_oe <= ~b_s.oe_n;
			porta_parity_flag <= par_err(a_s.data, par_even_q, 2'h0);
			portb_parity_flag <= par_err(b_s.data, par_even_q, b_last);
			if (dev_rst) begin
				mailbox1_new_mail <= 1'b0;
				mailbox2_new_mail <= 1'b0;
				porta_acknowledge <= 1'b0;
				portb_acknowledge <= 1'b0;
				if (a_go & ~a_s.rnw) begin
					portb_data_bus_out <= a_s.data;
				end else if (a_go) begin
					porta_data_bus_out <= b_s.data;
				end
			end else begin
				if (a_edge) begin
					porta_acknowledge <= a_wr_ok | a_rd_ok;
					mailbox2_new_mail <= mail_q[1];
				end
				if (b_edge) begin
					portb_acknowledge <= b_wr_ok | b_rd_ok;
					mailbox1_new_mail <= mail_q[0];
				end
				if (a_rd_ok) begin
					porta_data_bus_out <= head[1];
				end else if (a_mail_rd) begin
					porta_data_bus_out <= mb_q[1];
				end else if (a_go & a_s.rnw & (a_s.sel < `BDFM_SEL_CTRL || a_s.sel == `BDFM_SEL_OFS_ALL)) begin
					porta_data_bus_out <= {`BDFM_LANE'(af_q[1]), `BDFM_LANE'(ae_q[1]), `BDFM_LANE'(af_q[0]), `BDFM_LANE'(ae_q[0])};
				end
				if (b_rd_ok) begin
					portb_data_bus_out <= (head[0] >> piece_shift(b_rpc_q, b_last)) & piece_mask(b_last);
				end else if (b_mail_rd) begin
					portb_data_bus_out <= mb_q[0];
				end
			end
		end
	end

	// ==========================================================
	// Status flags, low-true, at the writing and reading ports
	bdfm_pkg::bdfm_flags_t flg_q [2];
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (clr) begin
				flg_q[i] <= '{full_n: 1'b1, afull_n: 1'b1, half_n: 1'b1, aempty_n: 1'b0, empty_n: 1'b0};
			end else begin
				flg_q[i].full_n <= ~full[i];
				flg_q[i].afull_n <= ~(cnt_q[i] >= CW'(DEPTH) - CW'(af_q[i]));
				flg_q[i].half_n <= ~(cnt_q[i] > CW'(DEPTH / 2));
				flg_q[i].aempty_n <= ~(cnt_q[i] <= CW'(ae_q[i]));
				flg_q[i].empty_n <= ~empty[i];
			end
		end
	end
	assign buf1_full_n = flg_q[0].full_n;
	assign buf1_almost_full_n = flg_q[0].afull_n;
	assign buf1_half_full_n = flg_q[0].half_n;
	assign buf1_almost_empty_n = flg_q[0].aempty_n;
	assign buf1_empty_n = flg_q[0].empty_n;
	assign buf2_full_n = flg_q[1].full_n;
	assign buf2_almost_full_n = flg_q[1].afull_n;
	assign buf2_half_full_n = flg_q[1].half_n;
	assign buf2_almost_empty_n = flg_q[1].aempty_n;
	assign buf2_empty_n = flg_q[1].empty_n;

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY
	assign ahb_take = hsel & hready & htrans[1];
	always_ff @(posedge clk) begin
		if (reset) begin
			ahb_wr_q <= 1'b0;
			ahb_addr_q <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ahb_wr_q <= ahb_take & hwrite;
			ahb_addr_q <= haddr[11:0];
			if (ahb_take & ~hwrite) begin
				unique case (haddr[11:0])
					`BDFM_ADDR_CTRL: hrdata <= 32'(par_even_q);
					`BDFM_ADDR_OFS: hrdata <= {`BDFM_OFS_BITS'(af_q[1]), `BDFM_OFS_BITS'(ae_q[1]),
						`BDFM_OFS_BITS'(af_q[0]), `BDFM_OFS_BITS'(ae_q[0])};
					`BDFM_ADDR_STAT: hrdata <= 32'({dev_rst, mail_q, 9'(cnt_q[1]), 9'(cnt_q[0])});
					default: hrdata <= '0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> bdfm_properties.sv
// Checker for the dual-buffer block, seen only through its top ports.
// Assumes it is bound to bdfm_top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module bdfm_properties (
	input wire logic clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic porta_output_enable_n, // Port A output enable pin.
	input wire logic porta_data_bus_oe, // Port A drive.
	input wire logic portb_output_enable_n, // Port B output enable pin.
	input wire logic portb_data_bus_oe, // Port B drive.
	input wire logic buf1_full_n, // Flag.
	input wire logic buf1_almost_full_n, // Flag.
	input wire logic buf1_half_full_n, // Flag.
	input wire logic buf1_almost_empty_n, // Flag.
	input wire logic buf1_empty_n, // Flag.
	input wire logic buf2_almost_empty_n, // Flag.
	input wire logic buf2_empty_n, // Flag.
	input wire logic porta_acknowledge // Port A answer.
);
	// ==========================================================
	// Flag consistency and output enables
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_full_sets_upper: assert property (!buf1_full_n |-> !buf1_almost_full_n && !buf1_half_full_n)
		else $error("full without almost full");
	a_empty_sets_lower: assert property (!buf1_empty_n |-> !buf1_almost_empty_n && buf1_full_n)
		else $error("empty flags disagree");
	a_empty2_sets_lower: assert property (!buf2_empty_n |-> !buf2_almost_empty_n)
		else $error("buffer 2 empty without almost empty");
	a_half_not_empty: assert property (!buf1_half_full_n |-> buf1_empty_n)
		else $error("half full while empty");
	a_oea_released: assert property (porta_output_enable_n [*8] |-> !porta_data_bus_oe)
		else $error("port A drives while disabled");
	a_oea_driven: assert property (!porta_output_enable_n [*8] |-> porta_data_bus_oe)
		else $error("port A silent while enabled");
	a_oeb_released: assert property (portb_output_enable_n [*8] |-> !portb_data_bus_oe)
		else $error("port B drives while disabled");
	a_oeb_driven: assert property (!portb_output_enable_n [*8] |-> portb_data_bus_oe)
		else $error("port B silent while enabled");
	cover property (!buf1_full_n);
	cover property (porta_acknowledge);
	cover property (!buf1_half_full_n ##1 buf1_half_full_n);
endmodule
bind bdfm_top bdfm_properties chk (.*);
`default_nettype wire

// >>> bdfm_port_host.sv
// Host logic on one port of the dual-buffer block.
// Assumes the caller resolves the bus level and paces it with clk.
`timescale 1ns/1ps
`default_nettype none
module bdfm_port_host (
	input wire logic clk, // Pacing clock.
	input wire logic ack, // Acknowledge from the block.
	input wire logic [35:0] bus, // Resolved bus level.
	output var logic pc, // Port clock, still between frames.
	output var logic en, // Enable.
	output var logic req, // Request.
	output var logic rw, // High reads.
	output var logic [2:0] s, // Resource select.
	output var logic oe_n, // Low lets the block drive.
	output var logic [35:0] d // Host drive level.
);
	initial begin
		{pc, en, req, rw, s, d} = '0;
		oe_n = 1'b1;
	end
	// Controls stay put 8 cycles either side of the edge, above the 5 the block needs.
	task automatic xfer(input logic r, input logic [2:0] a, input logic q, input logic [35:0] w,
		output logic k, output logic [35:0] rd);
		@(posedge clk);
		en <= 1'b1;
		req <= q;
		rw <= r;
		s <= a;
		oe_n <= ~r;
		d <= w;
		repeat (8) @(posedge clk);
		pc <= 1'b1;
		repeat (8) @(posedge clk);
		k = ack;
		rd = bus;
		pc <= 1'b0;
		repeat (6) @(posedge clk);
		{en, req} <= 2'h0;
		oe_n <= 1'b1;
		d <= ~w;
	endtask
endmodule
`default_nettype wire

// >>> bdfm_top_test.sv
// Self-checking bench for the dual-buffer block.
// Assumes port hosts on both sides and one AHB-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module bdfm_top_test;
	logic clk = 0, reset = 1, reset_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, ak;
	logic [1:0] htrans = 0, bx;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, hr;
	logic portb_width_select_0 = 0, portb_width_select_1 = 0, buf1_retransmit = 0, buf2_retransmit = 0;
	logic porta_clock, porta_enable, porta_request, porta_read_not_write, porta_output_enable_n;
	logic porta_select_0, porta_select_1, porta_select_2, porta_data_bus_oe, porta_acknowledge;
	logic portb_clock, portb_enable, portb_request, portb_read_not_write, portb_output_enable_n;
	logic portb_select, portb_data_bus_oe, portb_acknowledge, porta_parity_flag, portb_parity_flag;
	logic buf1_full_n, buf1_almost_full_n, buf1_half_full_n, buf1_almost_empty_n, buf1_empty_n;
	logic buf2_full_n, buf2_almost_full_n, buf2_half_full_n, buf2_almost_empty_n, buf2_empty_n;
	logic mailbox1_new_mail, mailbox2_new_mail;
	logic [35:0] porta_data_bus_in, porta_data_bus_out, portb_data_bus_in, portb_data_bus_out, pad, pbd, rd;
	int miscompares = 0, tests_run = 0, cyc = 0;
	initial forever #12.5 clk = ~clk;
	assign hready = hreadyout;
	assign porta_data_bus_in = porta_data_bus_oe ? porta_data_bus_out : pad;
	assign portb_data_bus_in = portb_data_bus_oe ? portb_data_bus_out : pbd;
	bdfm_top dut (.*);
	bdfm_port_host pa (.clk(clk), .ack(porta_acknowledge), .bus(porta_data_bus_in), .pc(porta_clock),
		.en(porta_enable), .req(porta_request), .rw(porta_read_not_write),
		.s({porta_select_2, porta_select_1, porta_select_0}), .oe_n(porta_output_enable_n), .d(pad));
	bdfm_port_host pb (.clk(clk), .ack(portb_acknowledge), .bus(portb_data_bus_in), .pc(portb_clock),
		.en(portb_enable), .req(portb_request), .rw(portb_read_not_write),
		.s({bx, portb_select}), .oe_n(portb_output_enable_n), .d(pbd));
	// ==========================================================
	// Shared tasks
	task stop_test;
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [35:0] g, input logic [35:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 20'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hr = hrdata;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			stop_test;
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		pa.xfer(0, 3'h7, 1, 36'h987654321, ak, rd);
		chk(portb_data_bus_out, 36'h987654321);
		repeat (30) @(posedge clk);
		reset_n <= 1'b1;
		repeat (20) @(posedge clk);
		chk(36'({buf1_empty_n, buf2_empty_n, buf1_almost_empty_n, buf2_almost_empty_n, buf1_full_n, buf2_full_n}), 36'h03);
		ahb(0, 12'h004, 0);
		chk(36'({hresp, hr}), 36'h008080808);
		ahb(0, 12'h00C, 0);
		chk(36'(hr), 36'h0);
		pa.xfer(1, 3'h5, 0, 0, ak, rd);
		chk(rd, 36'h040201008);
		pa.xfer(0, 3'h6, 0, 36'hFFFFFFFFF, ak, rd);
		repeat (10) @(posedge clk);
		chk(36'({porta_parity_flag, portb_parity_flag}), 36'h3);
		ahb(1, 12'h000, 1);
		repeat (10) @(posedge clk);
		chk(36'({porta_parity_flag, portb_parity_flag}), 36'h0);
		ahb(1, 12'h000, 0);
		pb.xfer(1, 3'h0, 0, 0, ak, rd);
		chk(rd, 36'hFFFFFFFFF);
		chk(36'(mailbox1_new_mail), 36'h1);
		for (int i = 0; i < 257; i++) begin
			pa.xfer(0, 3'h7, 1, {28'hA5A5A5A, i[7:0]}, ak, rd);
			chk(36'(ak), 36'(i < 256));
			chk(36'({buf1_full_n, buf1_almost_full_n, buf1_half_full_n}), 36'({i < 255, i < 247, i < 128}));
		end
		ahb(0, 12'h008, 0);
		chk(36'(hr[8:0]), 36'h100);
		for (int i = 0; i < 257; i++) begin
			pb.xfer(1, 3'h1, 1, 0, ak, rd);
			if (i == 0) chk(36'(mailbox1_new_mail), 36'h0);
			chk(36'(ak), 36'(i < 256));
			if (i < 256)
				chk(rd, {28'hA5A5A5A, i[7:0]});
			chk(36'({buf1_almost_empty_n, buf1_empty_n}), 36'({i < 247, i < 255}));
		end
		for (int i = 0; i < 7; i++) begin
			if (i < 3) begin
				pb.xfer(0, 3'h1, 1, 36'(i + 7), ak, rd);
				chk(36'({buf2_full_n, buf2_almost_full_n, buf2_half_full_n, buf2_almost_empty_n, buf2_empty_n}), 36'h1D);
			end else begin
				pa.xfer(1, 3'h7, 1, 0, ak, rd);
				chk(36'(ak), 36'(i < 6));
				chk(36'({buf2_almost_empty_n, buf2_empty_n}), 36'(i < 5));
				if (i < 6)
					chk(rd, 36'(i + 4));
			end
		end
		buf2_retransmit <= 1'b1;
		repeat (10) @(posedge clk);
		buf2_retransmit <= 1'b0;
		pa.xfer(1, 3'h7, 1, 0, ak, rd);
		chk(rd, 36'h7);
		portb_width_select_0 <= 1'b1;
		pb.xfer(0, 3'h1, 1, 36'h1234, ak, rd);
		pb.xfer(0, 3'h1, 1, 36'h5678, ak, rd);
		chk(36'(ak), 36'h1);
		for (int i = 0; i < 3; i++) begin
			pa.xfer(1, 3'h7, 1, 0, ak, rd);
			chk(rd, (i == 2) ? 36'h159E01234 : 36'(i + 8));
		end
		stop_test;
	end
endmodule
`default_nettype wire
